// ==== rtl/scan_bank_pkg.sv ====
// constants, field layouts and carrier types of the converter register bank
// assumes a 40 MHz core clock and a serial link clocked by the host
package scan_bank_pkg;

    // ****************************************************************
    // register addresses
    // ****************************************************************
    localparam logic [3:0] ADDR_FIXED       = 4'h2;
    localparam logic [3:0] ADDR_PAIR        = 4'h3;
    localparam logic [3:0] ADDR_SINGLE_LOW  = 4'h4;
    localparam logic [3:0] ADDR_SINGLE_HIGH = 4'h5;
    localparam logic [3:0] ADDR_INTERNAL    = 4'h6;
    localparam logic [3:0] ADDR_DIRECTION   = 4'h7;
    localparam logic [3:0] ADDR_PIN_DATA    = 4'h8;
    localparam logic [3:0] ADDR_IDENTITY    = 4'h9;

    // ****************************************************************
    // reset values and field layouts
    // ****************************************************************
    localparam logic [7:0] FIXED_RESET       = 8'h00;
    localparam logic [7:0] PAIR_RESET        = 8'h00;
    localparam logic [7:0] SINGLE_RESET      = 8'hFF;
    localparam logic [7:0] INTERNAL_RESET    = 8'h00;
    localparam logic [7:0] DIRECTION_RESET   = 8'hFF;
    localparam logic [7:0] PIN_DATA_RESET    = 8'h00;
    localparam logic [7:0] INTERNAL_WR_MASK  = 8'h3D;
    localparam int         BIT_OFFSET        = 0;
    localparam int         BIT_SUPPLY        = 2;
    localparam int         BIT_TEMP          = 3;
    localparam int         BIT_GAIN          = 4;
    localparam int         BIT_REFERENCE     = 5;
    localparam int         VARIANT_BIT       = 4;

    // ****************************************************************
    // scan table: 8 pairs, 16 single inputs, 5 internal readings
    // ****************************************************************
    localparam int         PAIR_COUNT        = 8;
    localparam int         SINGLE_COUNT      = 16;
    localparam int         ENTRY_COUNT       = 29;
    localparam logic [4:0] COMMON_INPUT      = 5'h10;
    localparam int         IMAGE_BYTES       = 8;

    // ****************************************************************
    // serial commands (top three bits of the command byte)
    // ****************************************************************
    localparam logic [2:0] CMD_READ          = 3'h2;
    localparam logic [2:0] CMD_WRITE         = 3'h3;
    localparam logic [2:0] CMD_CONVERT       = 3'h4;
    localparam logic [2:0] CMD_RESET         = 3'h6;
    localparam logic [3:0] BIT_CMD_DONE      = 4'h7;
    localparam logic [3:0] BIT_DATA_DONE     = 4'hF;

    typedef logic [IMAGE_BYTES-1:0][7:0] image_type;

    typedef struct packed {
        logic [7:0] fixed_input_pair_select;
        logic [7:0] scan_pair_enable;
        logic [7:0] scan_single_enable_low;
        logic [7:0] scan_single_enable_high;
        logic [7:0] internal_reading_enable;
        logic [7:0] port_direction;
        logic [7:0] port_pin_data;
    } regs_type;

    localparam regs_type REGS_RESET = '{FIXED_RESET, PAIR_RESET, SINGLE_RESET, SINGLE_RESET,
                                        INTERNAL_RESET, DIRECTION_RESET, PIN_DATA_RESET};

    // internal_sel: 0 none, 1 offset, 2 supply, 3 temperature, 4 gain, 5 reference
    typedef struct packed {
        logic       valid;
        logic [2:0] internal_sel;
        logic [4:0] positive_input_choice;
        logic [4:0] negative_input_choice;
    } meas_type;

endpackage : scan_bank_pkg

// ==== rtl/scan_reg_bank.sv ====
// register bank, serial register port and scan pointer of the converter
// assumes clk at 40 MHz, sclk from the host, mode 0 framing, cs_n may be tied low
//
// Function
// - fixed register: upper nibble positive, lower negative
// - pair bit k measures input 2k against 2k+1
// - single inputs measured against common return input
// - sequencer skips disabled entries
// - scan selection write resets channel pointer
// - scan bit one includes, zero excludes entry
// - internal enables at bits 5,4,3,2,0
// - single enables: low inputs 7-0, high 15-8
// - direction bit zero output, one input
// - bit n controls and reports pin n
// - data read returns sampled pin levels
// - data write sets driven level of outputs
// - written data ignored on input pins
// - identity register read-only, writes ignored
// - only identity bit four is stable
// - chip select high: ignore input, release output
// - link works with chip select tied low
// - serial convert and reset commands replace pins
// - power-off pin makes converter inactive
// - scan mode zero auto, one fixed
// - each mode's measurement output ignores the other's registers
`timescale 1ns/100ps

module scan_reg_bank #(
    parameter logic [7:0] IDENTITY_VALUE     = 8'h5A,  // arbitrary value
    parameter logic       RESOLUTION_VARIANT = 1'b0
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    scan_mode_select,
    input  wire logic                    advance_entry,
    input  wire logic                    power_off_pin,
    input  wire logic [7:0]              general_port_pin_in,
    output      logic [7:0]              general_port_pin_out,
    output      logic [7:0]              general_port_pin_oe,
    output      scan_bank_pkg::meas_type meas,
    output      logic [4:0]              scan_entry,
    output      logic                    converter_inactive,
    output      logic                    convert_pulse,
    output      logic                    reset_cmd_pulse,
    output      logic                    pointer_reset_pulse,
    input  wire logic                    sclk,
    input  wire logic                    cs_n,
    input  wire logic                    mosi,
    output      logic                    miso,
    output      logic                    miso_oe
);
    import scan_bank_pkg::*;

    // ****************************************************************
    // state types
    // ****************************************************************
    typedef struct packed {
        regs_type   regs;
        logic [7:0] pin_s1;
        logic [7:0] pin_s2;
        logic       pwr_s1;
        logic       pwr_s2;
        logic       wr_s1;
        logic       wr_s2;
        logic       wr_s3;
        logic       evt_s1;
        logic       evt_s2;
        logic       evt_s3;
        logic       ack_s1;
        logic       ack_s2;
        logic       req;
        image_type  hold;
        logic [4:0] ptr;
        meas_type   meas;
        logic       convert_p;
        logic       reset_p;
        logic       ptr_rst_p;
    } core_type;

    typedef struct packed {
        logic [3:0] bit_cnt;
        logic [6:0] shift;
        logic [7:0] cmd;
        logic [7:0] tx;
        logic       req_s1;
        logic       req_s2;
        logic       ack;
        image_type  image;
    } link_type;

    // cleared by rst only: outlives chip-select release
    typedef struct packed {
        logic       wr_tgl;
        logic [3:0] wr_addr;
        logic [7:0] wr_data;
        logic       evt_tgl;
        logic [2:0] evt_code;
    } cross_type;

    core_type   cq;
    core_type   cd;
    link_type   lq;
    link_type   ld;
    cross_type  xq;
    cross_type  xd;
    logic       miso_q;
    logic       link_clear;
    logic [7:0] byte_in;
    logic [28:0] entry_en;

    // first enabled entry after cur, or from the top when restart is set
    function automatic logic [4:0] next_entry(input logic [28:0] en, input logic [4:0] cur,
                                              input logic restart);
        logic [4:0] res;
        logic       found;
        int         idx;
        res   = cur;
        found = 1'b0;
        for (int i = 1; i <= ENTRY_COUNT; i++) begin
            idx = restart ? i - 1 : (int'(cur) + i) % ENTRY_COUNT;
            if (!found && en[idx]) begin
                res   = 5'(idx);
                found = 1'b1;
            end
        end
        return res;
    endfunction : next_entry

    function automatic meas_type decode(input logic [4:0] p, input logic [28:0] en, input regs_type r,
                                        input logic fixed_mode);
        meas_type m;
        m = '0;
        if (fixed_mode) begin
            m.valid                 = 1'b1;
            m.positive_input_choice = {1'b0, r.fixed_input_pair_select[7:4]};
            m.negative_input_choice = {1'b0, r.fixed_input_pair_select[3:0]};
        end else if (int'(p) < PAIR_COUNT) begin
            m.valid                 = en[p];
            m.positive_input_choice = 5'({p[2:0], 1'b0});
            m.negative_input_choice = 5'({p[2:0], 1'b1});
        end else if (int'(p) < PAIR_COUNT + SINGLE_COUNT) begin
            m.valid                 = en[p];
            m.positive_input_choice = 5'(int'(p) - PAIR_COUNT);
            m.negative_input_choice = COMMON_INPUT;
        end else begin
            m.valid                 = en[p];
            m.internal_sel          = 3'(int'(p) - PAIR_COUNT - SINGLE_COUNT + 1);
        end
        return m;
    endfunction : decode

    // ****************************************************************
    // core domain
    // ****************************************************************
    always_comb begin
        logic       wr_evt;
        logic       cmd_evt;
        logic       restart;
        cd           = cq;
        cd.pin_s1    = general_port_pin_in;
        cd.pin_s2    = cq.pin_s1;
        cd.pwr_s1    = power_off_pin;
        cd.pwr_s2    = cq.pwr_s1;
        cd.wr_s1     = xq.wr_tgl;
        cd.wr_s2     = cq.wr_s1;
        cd.wr_s3     = cq.wr_s2;
        cd.evt_s1    = xq.evt_tgl;
        cd.evt_s2    = cq.evt_s1;
        cd.evt_s3    = cq.evt_s2;
        cd.ack_s1    = lq.ack;
        cd.ack_s2    = cq.ack_s1;
        cd.convert_p = 1'b0;
        cd.reset_p   = 1'b0;
        cd.ptr_rst_p = 1'b0;
        wr_evt       = cq.wr_s2 ^ cq.wr_s3;
        cmd_evt      = cq.evt_s2 ^ cq.evt_s3;
        restart      = 1'b0;
        if (wr_evt) begin
            if (xq.wr_addr == ADDR_FIXED) begin
                cd.regs.fixed_input_pair_select = xq.wr_data;
            end else if (xq.wr_addr == ADDR_PAIR) begin
                cd.regs.scan_pair_enable = xq.wr_data;
                restart = 1'b1;
            end else if (xq.wr_addr == ADDR_SINGLE_LOW) begin
                cd.regs.scan_single_enable_low = xq.wr_data;
                restart = 1'b1;
            end else if (xq.wr_addr == ADDR_SINGLE_HIGH) begin
                cd.regs.scan_single_enable_high = xq.wr_data;
                restart = 1'b1;
            end else if (xq.wr_addr == ADDR_INTERNAL) begin
                cd.regs.internal_reading_enable = xq.wr_data & INTERNAL_WR_MASK;
                restart = 1'b1;
            end else if (xq.wr_addr == ADDR_DIRECTION) begin
                cd.regs.port_direction = xq.wr_data;
            end else if (xq.wr_addr == ADDR_PIN_DATA) begin
                cd.regs.port_pin_data = xq.wr_data;
            end
            // identity and unmapped addresses take no write
        end
        if (cmd_evt && xq.evt_code == CMD_CONVERT) begin
            cd.convert_p = ~cq.pwr_s2;
        end
        if (cmd_evt && xq.evt_code == CMD_RESET) begin
            cd.regs    = REGS_RESET;
            cd.reset_p = 1'b1;
            restart    = 1'b1;
        end
        entry_en = {cd.regs.internal_reading_enable[BIT_REFERENCE],
                    cd.regs.internal_reading_enable[BIT_GAIN],
                    cd.regs.internal_reading_enable[BIT_TEMP],
                    cd.regs.internal_reading_enable[BIT_SUPPLY],
                    cd.regs.internal_reading_enable[BIT_OFFSET],
                    cd.regs.scan_single_enable_high,
                    cd.regs.scan_single_enable_low,
                    cd.regs.scan_pair_enable};
        // restart beats a same-cycle advance, so the next index starts at the top
        cd.ptr_rst_p = restart;
        if (restart) begin
            cd.ptr = next_entry(entry_en, cq.ptr, 1'b1);
        end else if (advance_entry && !cq.pwr_s2 && !scan_mode_select) begin
            cd.ptr = next_entry(entry_en, cq.ptr, 1'b0);
        end
        cd.meas = decode(cd.ptr, entry_en, cd.regs, scan_mode_select);
        if (cq.ack_s2 == cq.req) begin
            cd.hold = {IDENTITY_VALUE[7:5], RESOLUTION_VARIANT, IDENTITY_VALUE[3:0],
                       cq.pin_s2,
                       cq.regs.port_direction,
                       cq.regs.internal_reading_enable,
                       cq.regs.scan_single_enable_high,
                       cq.regs.scan_single_enable_low,
                       cq.regs.scan_pair_enable,
                       cq.regs.fixed_input_pair_select};
            cd.req  = ~cq.req;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cq      <= '0;
            cq.regs <= REGS_RESET;
        end else begin
            cq <= cd;
        end
    end

    // ****************************************************************
    // link domain
    // ****************************************************************
    assign link_clear = cs_n | rst;
    assign byte_in    = {lq.shift, mosi};

    always_comb begin
        ld         = lq;
        xd         = xq;
        ld.bit_cnt = lq.bit_cnt + 4'h1;
        ld.shift   = byte_in[6:0];
        ld.tx      = {lq.tx[6:0], 1'b0};
        ld.req_s1  = cq.req;
        ld.req_s2  = lq.req_s1;
        if (lq.bit_cnt == BIT_CMD_DONE) begin
            ld.cmd = byte_in;
            if (byte_in[7:5] == CMD_READ) begin
                if (byte_in[3:0] >= ADDR_FIXED && byte_in[3:0] <= ADDR_IDENTITY) begin
                    ld.tx = lq.image[3'(byte_in[3:0] - ADDR_FIXED)];
                end else begin
                    ld.tx = 8'h00;
                end
            end
            if (byte_in[7:5] == CMD_CONVERT || byte_in[7:5] == CMD_RESET) begin
                xd.evt_code = byte_in[7:5];
                xd.evt_tgl  = ~xq.evt_tgl;
            end
        end
        if (lq.bit_cnt == BIT_DATA_DONE && lq.cmd[7:5] == CMD_WRITE) begin
            xd.wr_addr = lq.cmd[3:0];
            xd.wr_data = byte_in;
            xd.wr_tgl  = ~xq.wr_tgl;
        end
        if (lq.req_s2 != lq.ack) begin
            ld.image = cq.hold;
            ld.ack   = lq.req_s2;
        end
    end

    always_ff @(posedge sclk or posedge link_clear) begin
        if (link_clear) begin
            lq <= '0;
        end else begin
            lq <= ld;
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            xq <= '0;
        end else begin
            xq <= xd;
        end
    end

    always_ff @(negedge sclk or posedge link_clear) begin
        if (link_clear) begin
            miso_q <= 1'b0;
        end else begin
            miso_q <= lq.tx[7];
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign miso                 = miso_q;
    assign miso_oe              = ~cs_n;
    assign general_port_pin_out = cq.regs.port_pin_data;
    assign general_port_pin_oe  = ~cq.regs.port_direction;
    assign meas                 = cq.meas;
    assign scan_entry           = cq.ptr;
    assign converter_inactive   = cq.pwr_s2;
    assign convert_pulse        = cq.convert_p;
    assign reset_cmd_pulse      = cq.reset_p;
    assign pointer_reset_pulse  = cq.ptr_rst_p;

endmodule : scan_reg_bank

// ==== test/adc_channel_gpio_register_bank_tb_top.sv ====
// self-checking bench of the converter register bank
// assumes spi_host_model and the bound checker are compiled before it
`timescale 1ns/100ps
module adc_channel_gpio_register_bank_tb_top;
    import scan_bank_pkg::*;
    localparam logic [7:0] ID_VALUE = 8'h47; // arbitrary value
    localparam int         SEL_BIT[5] = '{BIT_OFFSET, BIT_SUPPLY, BIT_TEMP, BIT_GAIN, BIT_REFERENCE};
    logic       clk, rst, scan_mode_select, advance_entry, power_off_pin;
    logic [7:0] pin_ext, general_port_pin_in, general_port_pin_out, general_port_pin_oe, rx;
    meas_type   meas;
    logic [4:0] scan_entry;
    logic       converter_inactive, convert_pulse, reset_cmd_pulse, pointer_reset_pulse;
    logic       sclk, cs_n, mosi, miso, miso_oe;
    int         fail_count, tests_run, cycles, conv_seen;
    // wire level of each port pin from both drivers
    assign general_port_pin_in = (general_port_pin_oe & general_port_pin_out) | (~general_port_pin_oe & pin_ext);
    scan_reg_bank #(.IDENTITY_VALUE(ID_VALUE), .RESOLUTION_VARIANT(1'b1)) u_scan_reg_bank (.clk(clk), .rst(rst),
        .scan_mode_select(scan_mode_select), .advance_entry(advance_entry), .power_off_pin(power_off_pin),
        .general_port_pin_in(general_port_pin_in), .general_port_pin_out(general_port_pin_out),
        .general_port_pin_oe(general_port_pin_oe), .meas(meas), .scan_entry(scan_entry),
        .converter_inactive(converter_inactive), .convert_pulse(convert_pulse), .reset_cmd_pulse(reset_cmd_pulse),
        .pointer_reset_pulse(pointer_reset_pulse), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
        .miso_oe(miso_oe));
    spi_host_model u_spi_host_model (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(negedge clk) begin
        cycles++;
        if (convert_pulse === 1'b1) conv_seen++;
        if (cycles == 30000) begin
            fail_count++;
            test_done();
        end
    end
    // ****************************************************************
    // access and compare tasks
    // ****************************************************************
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic reg_wr(input logic [3:0] addr, input logic [7:0] data);
        u_spi_host_model.xfer({CMD_WRITE, 1'b0, addr, data}, 1'b0, rx);
        repeat (8) @(negedge clk);
    endtask : reg_wr
    task automatic reg_rd(input logic [3:0] addr, input logic [7:0] exp, input string what);
        u_spi_host_model.xfer({CMD_READ, 1'b0, addr, 8'h00}, 1'b0, rx);
        check(what, {16'h0, exp}, {16'h0, rx});
    endtask : reg_rd
    task automatic command(input logic [2:0] code, input logic hold_low);
        u_spi_host_model.xfer({code, 13'h0}, hold_low, rx);
        repeat (8) @(negedge clk);
    endtask : command
    task automatic step;
        @(negedge clk) advance_entry = 1'b1;
        @(negedge clk) advance_entry = 1'b0;
        repeat (2) @(negedge clk);
    endtask : step
    task automatic meas_chk(input logic [2:0] sel, input logic [4:0] entry, input logic [4:0] pos,
                            input logic [4:0] neg);
        check("meas", {5'h0, 1'b1, sel, entry, pos, neg}, {5'h0, meas.valid, meas.internal_sel, scan_entry,
              meas.positive_input_choice, meas.negative_input_choice});
    endtask : meas_chk
    task automatic test_done;
        $display("tests_run %0d fail_count %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done
    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        {rst, scan_mode_select, advance_entry, power_off_pin, pin_ext} = {4'b1000, 8'h3C};
        {fail_count, tests_run, cycles, conv_seen} = '0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (6) @(negedge clk);
        reg_rd(ADDR_FIXED, 8'h00, "fixed");
        reg_rd(ADDR_PAIR, 8'h00, "pair");
        reg_rd(ADDR_SINGLE_LOW, 8'hFF, "single low");
        reg_rd(ADDR_SINGLE_HIGH, 8'hFF, "single high");
        reg_rd(ADDR_INTERNAL, 8'h00, "internal");
        reg_rd(ADDR_DIRECTION, 8'hFF, "direction");
        reg_rd(ADDR_PIN_DATA, 8'h3C, "pin data");
        reg_wr(ADDR_IDENTITY, 8'h00);
        reg_rd(ADDR_IDENTITY, {ID_VALUE[7:5], 1'b1, ID_VALUE[3:0]}, "identity");
        reg_wr(4'hA, 8'h55);
        reg_rd(4'hA, 8'h00, "unmapped");
        $display("test reset values done");
        scan_mode_select = 1'b1;
        reg_wr(ADDR_FIXED, 8'hA5);
        reg_rd(ADDR_FIXED, 8'hA5, "fixed");
        meas_chk(3'h0, 5'd0, 5'h0A, 5'h05);
        reg_wr(ADDR_PAIR, 8'h81);
        meas_chk(3'h0, 5'd0, 5'h0A, 5'h05);
        scan_mode_select = 1'b0;
        reg_wr(ADDR_SINGLE_LOW, 8'h00);
        reg_wr(ADDR_SINGLE_HIGH, 8'h00);
        reg_wr(ADDR_INTERNAL, 8'h00);
        meas_chk(3'h0, 5'd0, 5'd0, 5'd1);
        step();
        meas_chk(3'h0, 5'd7, 5'd14, 5'd15);
        step();
        meas_chk(3'h0, 5'd0, 5'd0, 5'd1);
        step();
        reg_wr(ADDR_PAIR, 8'h81);
        meas_chk(3'h0, 5'd0, 5'd0, 5'd1);
        reg_wr(ADDR_PAIR, 8'h00);
        reg_wr(ADDR_SINGLE_HIGH, 8'h02);
        meas_chk(3'h0, 5'd17, 5'd9, COMMON_INPUT);
        reg_wr(ADDR_SINGLE_HIGH, 8'h00);
        for (int k = 0; k < 5; k++) begin
            reg_wr(ADDR_INTERNAL, 8'h01 << SEL_BIT[k]);
            meas_chk(3'(k + 1), 5'(24 + k), 5'd0, 5'd0);
        end
        $display("test scan selection done");
        reg_wr(ADDR_DIRECTION, 8'h0F);
        reg_wr(ADDR_PIN_DATA, 8'hA5);
        check("pin oe", 24'hF0, {16'h0, general_port_pin_oe});
        check("pin drive", 24'hA0, {16'h0, general_port_pin_out & general_port_pin_oe});
        reg_rd(ADDR_PIN_DATA, 8'hAC, "pin data");
        reg_wr(ADDR_PIN_DATA, 8'h5A);
        reg_rd(ADDR_PIN_DATA, 8'h5C, "pin data");
        $display("test port pins done");
        command(CMD_CONVERT, 1'b0);
        check("convert count", 24'd1, 24'(conv_seen));
        power_off_pin = 1'b1;
        repeat (6) @(negedge clk);
        check("inactive", 24'h1, {23'h0, converter_inactive});
        command(CMD_CONVERT, 1'b0);
        check("convert count", 24'd1, 24'(conv_seen));
        power_off_pin = 1'b0;
        command(CMD_RESET, 1'b1);
        u_spi_host_model.xfer({CMD_READ, 1'b0, ADDR_DIRECTION, 8'h00}, 1'b1, rx);
        check("direction", 24'hFF, {16'h0, rx});
        check("pin oe", 24'h00, {16'h0, general_port_pin_oe});
        $display("test commands done");
        test_done();
    end
endmodule : adc_channel_gpio_register_bank_tb_top

// ==== test/scan_reg_bank_chk.sv ====
// concurrent checks on the ports of the converter register bank
// assumes clk is the core clock and rst its synchronous active-high reset
`timescale 1ns/100ps
module scan_reg_bank_chk (
    input wire logic                    clk,
    input wire logic                    rst,
    input wire logic                    scan_mode_select,
    input wire logic                    advance_entry,
    input wire logic                    power_off_pin,
    input wire logic [7:0]              general_port_pin_in,
    input wire logic [7:0]              general_port_pin_out,
    input wire logic [7:0]              general_port_pin_oe,
    input wire scan_bank_pkg::meas_type meas,
    input wire logic [4:0]              scan_entry,
    input wire logic                    converter_inactive,
    input wire logic                    convert_pulse,
    input wire logic                    reset_cmd_pulse,
    input wire logic                    pointer_reset_pulse,
    input wire logic                    sclk,
    input wire logic                    cs_n,
    input wire logic                    mosi,
    input wire logic                    miso,
    input wire logic                    miso_oe
);
    import scan_bank_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ****************************************************************
    // sequences and properties
    // ****************************************************************
    sequence s_auto_held;
        !scan_mode_select ##1 !scan_mode_select;
    endsequence
    sequence s_ptr_quiet;
        !pointer_reset_pulse ##1 (!advance_entry && !pointer_reset_pulse) ##1 !pointer_reset_pulse;
    endsequence
    property p_pair_decode;
        s_auto_held ##0 (scan_entry < 5'd8) |-> meas.positive_input_choice == {scan_entry[3:0], 1'b0}
            && meas.negative_input_choice == {scan_entry[3:0], 1'b1} && meas.internal_sel == 3'h0;
    endproperty
    property p_single_decode;
        s_auto_held ##0 (scan_entry >= 5'd8 && scan_entry < 5'd24) |->
            meas.positive_input_choice == scan_entry - 5'd8 && meas.negative_input_choice == COMMON_INPUT;
    endproperty
    property p_internal_decode;
        s_auto_held ##0 (scan_entry >= 5'd24) |-> meas.internal_sel == scan_entry[2:0] + 3'h1;
    endproperty
    property p_fixed_decode;
        scan_mode_select |=> meas.valid && meas.internal_sel == 3'h0
            && !meas.positive_input_choice[4] && !meas.negative_input_choice[4];
    endproperty
    property p_ptr_hold;
        s_ptr_quiet |-> $stable(scan_entry);
    endproperty
    property p_release_defaults;
        $fell(rst) |-> general_port_pin_oe == 8'h00 && general_port_pin_out == 8'h00 && scan_entry == 5'h00;
    endproperty
    property p_miso_release;
        miso_oe == !cs_n;
    endproperty
    property p_pulse_single;
        convert_pulse || reset_cmd_pulse |=> !convert_pulse && !reset_cmd_pulse;
    endproperty
    property p_power_off;
        $rose(power_off_pin) |-> ##[1:4] converter_inactive;
    endproperty
    property p_no_convert_off;
        converter_inactive && $past(converter_inactive) |-> !convert_pulse;
    endproperty
    property p_reset_cmd;
        reset_cmd_pulse |-> ##[0:4] (pointer_reset_pulse ##[0:4] general_port_pin_oe == 8'h00);
    endproperty
    // ****************************************************************
    // assertions
    // ****************************************************************
    a_pair_decode: assert property (p_pair_decode) else $error("pair decode wrong");
    a_single_decode: assert property (p_single_decode) else $error("single decode wrong");
    a_internal_decode: assert property (p_internal_decode) else $error("internal decode wrong");
    a_fixed_decode: assert property (p_fixed_decode) else $error("fixed decode wrong");
    a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved unasked");
    a_release_defaults: assert property (p_release_defaults) else $error("reset state wrong");
    a_miso_release: assert property (p_miso_release) else $error("serial out enable wrong");
    a_pulse_single: assert property (p_pulse_single) else $error("command pulse too long");
    a_power_off: assert property (p_power_off) else $error("power off not seen");
    a_no_convert_off: assert property (p_no_convert_off) else $error("convert while inactive");
    a_reset_cmd: assert property (p_reset_cmd) else $error("reset command incomplete");
endmodule : scan_reg_bank_chk

bind scan_reg_bank scan_reg_bank_chk u_scan_reg_bank_chk (.clk(clk), .rst(rst),
    .scan_mode_select(scan_mode_select), .advance_entry(advance_entry), .power_off_pin(power_off_pin),
    .general_port_pin_in(general_port_pin_in), .general_port_pin_out(general_port_pin_out),
    .general_port_pin_oe(general_port_pin_oe), .meas(meas), .scan_entry(scan_entry),
    .converter_inactive(converter_inactive), .convert_pulse(convert_pulse), .reset_cmd_pulse(reset_cmd_pulse),
    .pointer_reset_pulse(pointer_reset_pulse), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe));

// ==== test/spi_host_model.sv ====
// serial host model: frames 16-bit commands, mode 0, link clock 125 ns
// assumes the bench calls xfer; the link clock stands low between frames
`timescale 1ns/100ps
module spi_host_model (
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic miso
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    task automatic xfer(input logic [15:0] tx, input logic hold_low, output logic [7:0] rx);
        #5;
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi = tx[i];
            #62.5 sclk = 1'b1;
            if (i < 8) rx[i] = miso;
            #62.5 sclk = 1'b0;
        end
        // released line shows the opposite of its last bit, not a stale copy
        mosi = ~mosi;
        if (!hold_low) cs_n = 1'b1;
        #245;
    endtask : xfer
endmodule : spi_host_model
